// File: logic/lbm_cfg.svh
`ifndef LBM_CFG_SVH
`define LBM_CFG_SVH

// Number of synchroniser flip-flops that the grant, strobe and acknowledge pins pass before the accept register.
`define LBM_SYNC_STAGES 3
// Number of pins that are synchronised: grant, address strobe, acknowledge.
`define LBM_PIN_COUNT   3
// Bit positions of the synchronised pins inside the pin vector.
`define LBM_PIN_GRANT   0
`define LBM_PIN_STROBE  1
`define LBM_PIN_ACK     2
// Width of the programmable I/O wait-state count.
`define LBM_WAIT_W      4
// Reset values: synchronous acknowledge and no wait states.
`define LBM_RST_ASYNC   1'b0
`define LBM_RST_WAITS   4'h0
// Reset value of the read-data latch; the byte bus drive value is not reset.
`define LBM_RST_BYTE    8'h00
// Synchronised pins settle high (inactive) after reset.
`define LBM_RST_PINS    3'h7

`endif

// File: logic/lbm_pkg.sv
package lbm_pkg;

    // Mastership sequence; Gray codes along idle, request, own, transfer.
    typedef enum logic [1:0] {
        LBM_M_IDLE = 2'b00,
        LBM_M_REQ  = 2'b01,
        LBM_M_OWN  = 2'b11,
        LBM_M_XFER = 2'b10
    } lbm_mst_state_t;

    // Target acknowledge sequence; Gray codes along idle, wait, acknowledge.
    typedef enum logic [1:0] {
        LBM_T_IDLE = 2'b00,
        LBM_T_WAIT = 2'b01,
        LBM_T_ACK  = 2'b11
    } lbm_tgt_state_t;

    // One local transfer that the block masters.
    typedef struct packed {
        logic       write;
        logic [7:0] wdata;
    } lbm_xfer_t;

    // Acknowledge configuration loaded by the card's control logic.
    typedef struct packed {
        logic       async_mode;
        logic [3:0] io_waits;
    } lbm_ack_cfg_t;

endpackage : lbm_pkg

// File: logic/lbm_bridge.sv
`timescale 1ns/1ps
`include "lbm_cfg.svh"

// Function
// - Request low while any served requester needs bus.
// - Wait for grant low before taking bus.
// - Assert mastership taken once bus is ours.
// - Internal 20 MHz from two phase clocks.
// - Card 10 MHz clock out from the late phase clock.
// - Eight-bit bidirectional active-high local data path.
// - Collision: drive fault and halt low.
// - Halt held until attention void cycle occurs.
// - Fault released after strobe high, independent of halt.
// - Master read: latch data when acknowledge low.
// - Master write ends when acknowledge goes low.
// - Target read: drive acknowledge low for data.
// - RAM or I/O acknowledge, I/O waits programmable.
// - Sync or async acknowledge, sync after reset.
module lbm_bridge (
    input  wire logic                  clk_i,                     // System clock, 10 MHz.
    input  wire logic                  sys_rst_i,                 // Asynchronous reset, high.
    input  wire logic                  phase_clock_early_i,       // Early phase clock pin.
    input  wire logic                  phase_clock_late_i,        // Late phase clock pin.
    output logic                       internal_clk20_o,          // Derived 20 MHz clock.
    output logic                       card_clock_out_o,          // 10 MHz card clock.
    input  wire logic                  exp_bus_req_i,             // Expansion bus needs the bus.
    input  wire logic                  io_side_bus_req_i,         // I/O side bus needs the bus.
    output logic                       mastership_request_out_n_o,// Request to processor, low.
    input  wire logic                  grant_in_n_i,              // Grant from processor, low.
    output logic                       mastership_taken_n_o,      // Mastership taken, low.
    input  wire logic                  xfer_start_i,              // Start one mastered transfer.
    input  wire lbm_pkg::lbm_xfer_t    xfer_i,                    // Direction and write data.
    output logic                       xfer_ready_o,              // Transfer may be started.
    output logic                       xfer_done_o,               // Transfer finished, pulse.
    output logic [7:0]                 xfer_rdata_o,              // Latched read data.
    input  wire logic                  addr_valid_strobe_n_i,     // Address strobe pin, low.
    input  wire logic                  transfer_done_ack_n_i,     // Acknowledge pin level.
    output logic                       transfer_done_ack_n_o,     // Acknowledge drive value.
    output logic                       transfer_done_ack_oe_o,    // Acknowledge drive enable.
    input  wire logic [7:0]            local_byte_bus_i,          // Byte bus pin level.
    output logic [7:0]                 local_byte_bus_o,          // Byte bus drive value.
    output logic                       local_byte_bus_oe_o,       // Byte bus drive enable.
    input  wire logic                  tgt_req_i,                 // Processor access decoded.
    input  wire logic                  tgt_read_i,                // Processor access is a read.
    input  wire logic                  tgt_is_io_i,               // Address range is I/O type.
    input  wire logic                  tgt_data_ready_i,          // Async mode data ready.
    input  wire logic [7:0]            tgt_rdata_i,               // Data for processor reads.
    input  wire logic                  cfg_load_i,                // Load acknowledge config.
    input  wire lbm_pkg::lbm_ack_cfg_t cfg_i,                     // New acknowledge config.
    input  wire logic                  collision_i,               // Incoming traffic collision.
    input  wire logic                  attention_void_cycle_i,    // Attention void cycle seen.
    output logic                       fault_to_processor_n_o,    // Bus error, low.
    output logic                       halt_n_o                   // Halt, low.
);

    // Three-stage chains for the asynchronous pins.
    logic [`LBM_PIN_COUNT-1:0] pin_raw;            // Raw pin vector.
    logic [`LBM_PIN_COUNT-1:0] pin_s1_r;           // First stage, read only by the second.
    logic [`LBM_PIN_COUNT-1:0] pin_s2_r;           // Second stage.
    logic [`LBM_PIN_COUNT-1:0] pin_s3_r;           // Third stage.
    logic [`LBM_PIN_COUNT-1:0] pin_r;              // Accepted pin level.
    logic [`LBM_PIN_COUNT-1:0] pin_nxt;            // Next accepted level.
    logic                      grant_low;          // Grant seen low.
    logic                      strobe_high;        // Address strobe seen high.
    logic                      ack_low;            // Acknowledge seen low.

    // Mastership state.
    lbm_pkg::lbm_mst_state_t   mst_r;              // Master sequence state.
    lbm_pkg::lbm_mst_state_t   mst_nxt;            // Next master state.
    lbm_pkg::lbm_xfer_t        cur_r;              // Transfer in flight.
    lbm_pkg::lbm_xfer_t        cur_nxt;            // Next transfer in flight.
    logic [7:0]                rdata_r;            // Read data latch.
    logic [7:0]                rdata_nxt;          // Next read data.
    logic                      done_r;             // Done pulse register.
    logic                      done_nxt;           // Next done pulse.

    // Target acknowledge state.
    lbm_pkg::lbm_tgt_state_t   tgt_r;              // Target sequence state.
    lbm_pkg::lbm_tgt_state_t   tgt_nxt;            // Next target state.
    logic [`LBM_WAIT_W-1:0]    wait_r;             // Wait-state down counter.
    logic [`LBM_WAIT_W-1:0]    wait_nxt;           // Next wait count.
    logic                      tgt_rd_r;           // Access being acknowledged is a read.
    logic                      tgt_rd_nxt;         // Next read flag.
    lbm_pkg::lbm_ack_cfg_t     cfg_r;              // Active acknowledge config.
    lbm_pkg::lbm_ack_cfg_t     cfg_nxt;            // Next acknowledge config.

    // Relinquish-and-retry flags, stored active high.
    logic                      fault_r;            // Bus error asserted.
    logic                      fault_nxt;          // Next bus error.
    logic                      halt_r;             // Halt asserted.
    logic                      halt_nxt;           // Next halt.

    // Both phase clocks come from one delay line, so the exclusive-or of the two
    // toggles every quarter of the bus period and gives the doubled clock.
    assign internal_clk20_o = phase_clock_early_i ^ phase_clock_late_i;
    // The late phase already runs at 10 MHz, so it is buffered out as the card clock.
    assign card_clock_out_o = phase_clock_late_i;

    // Gather the pins that need synchronising.
    always_comb begin
        pin_raw                  = '0;
        pin_raw[`LBM_PIN_GRANT]  = grant_in_n_i;
        pin_raw[`LBM_PIN_STROBE] = addr_valid_strobe_n_i;
        pin_raw[`LBM_PIN_ACK]    = transfer_done_ack_n_i;
    end

    // A pin change is accepted only once the second and third stages agree,
    // which filters a single-cycle glitch without delaying a steady change.
    generate
        for (genvar gi = 0; gi < `LBM_PIN_COUNT; gi++) begin : g_pin
            always_comb begin
                pin_nxt[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) ? pin_s3_r[gi] : pin_r[gi];
            end
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    pin_s1_r[gi] <= 1'b1;
                    pin_s2_r[gi] <= 1'b1;
                    pin_s3_r[gi] <= 1'b1;
                    pin_r[gi]    <= 1'b1;
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    pin_r[gi]    <= pin_nxt[gi];
                end
            end
        end
    endgenerate

    assign grant_low   = ~pin_r[`LBM_PIN_GRANT];
    assign strobe_high =  pin_r[`LBM_PIN_STROBE];
    assign ack_low     = ~pin_r[`LBM_PIN_ACK];

    // Master sequence: request, wait for grant, own the bus, run transfers.
    always_comb begin
        mst_nxt   = mst_r;
        cur_nxt   = cur_r;
        rdata_nxt = rdata_r;
        done_nxt  = 1'b0;
        case (mst_r)
            lbm_pkg::LBM_M_IDLE: begin
                // A grant left from the last tenure must clear before a new request.
                if ((exp_bus_req_i || io_side_bus_req_i) && !grant_low) begin
                    mst_nxt = lbm_pkg::LBM_M_REQ;
                end
            end
            lbm_pkg::LBM_M_REQ: begin
                // The previous master must also have let the strobe go.
                if (grant_low && strobe_high) begin
                    mst_nxt = lbm_pkg::LBM_M_OWN;
                end
            end
            lbm_pkg::LBM_M_OWN: begin
                if (xfer_start_i && !ack_low) begin
                    cur_nxt = xfer_i;
                    mst_nxt = lbm_pkg::LBM_M_XFER;
                end else if (!exp_bus_req_i && !io_side_bus_req_i) begin
                    mst_nxt = lbm_pkg::LBM_M_IDLE;
                end
            end
            lbm_pkg::LBM_M_XFER: begin
                // The addressed device ends the cycle with its acknowledge.
                if (ack_low) begin
                    if (!cur_r.write) begin
                        rdata_nxt = local_byte_bus_i;
                    end
                    done_nxt = 1'b1;
                    mst_nxt  = lbm_pkg::LBM_M_OWN;
                end
            end
            default: begin
                mst_nxt = lbm_pkg::LBM_M_IDLE;
            end
        endcase
    end

    // Master registers.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mst_r   <= lbm_pkg::LBM_M_IDLE;
            cur_r   <= '0;
            rdata_r <= `LBM_RST_BYTE;
            done_r  <= 1'b0;
        end else begin
            mst_r   <= mst_nxt;
            cur_r   <= cur_nxt;
            rdata_r <= rdata_nxt;
            done_r  <= done_nxt;
        end
    end

    // Request stays low through the whole tenure; taken marks ownership.
    assign mastership_request_out_n_o = (mst_r == lbm_pkg::LBM_M_IDLE);
    assign mastership_taken_n_o       = ~((mst_r == lbm_pkg::LBM_M_OWN) ||
                                          (mst_r == lbm_pkg::LBM_M_XFER));
    assign xfer_ready_o = (mst_r == lbm_pkg::LBM_M_OWN) && !ack_low;
    assign xfer_done_o  = done_r;
    assign xfer_rdata_o = rdata_r;

    // Target acknowledge sequence for processor accesses to the block.
    always_comb begin
        tgt_nxt    = tgt_r;
        wait_nxt   = wait_r;
        tgt_rd_nxt = tgt_rd_r;
        cfg_nxt    = cfg_load_i ? cfg_i : cfg_r;
        case (tgt_r)
            lbm_pkg::LBM_T_IDLE: begin
                if (tgt_req_i && !strobe_high) begin
                    tgt_rd_nxt = tgt_read_i;
                    // I/O ranges count wait states; RAM ranges need none.
                    wait_nxt   = tgt_is_io_i ? cfg_r.io_waits : '0;
                    tgt_nxt    = lbm_pkg::LBM_T_WAIT;
                end
            end
            lbm_pkg::LBM_T_WAIT: begin
                if (strobe_high) begin
                    tgt_nxt = lbm_pkg::LBM_T_IDLE;
                end else if (wait_r != '0) begin
                    wait_nxt = wait_r - 1'b1;
                end else if (!cfg_r.async_mode || tgt_data_ready_i) begin
                    tgt_nxt = lbm_pkg::LBM_T_ACK;
                end
            end
            lbm_pkg::LBM_T_ACK: begin
                // Held until the processor drops its strobe and ends the cycle.
                if (strobe_high) begin
                    tgt_nxt = lbm_pkg::LBM_T_IDLE;
                end
            end
            default: begin
                tgt_nxt = lbm_pkg::LBM_T_IDLE;
            end
        endcase
    end

    // Target registers.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgt_r            <= lbm_pkg::LBM_T_IDLE;
            wait_r           <= '0;
            tgt_rd_r         <= 1'b0;
            cfg_r.async_mode <= `LBM_RST_ASYNC;
            cfg_r.io_waits   <= `LBM_RST_WAITS;
        end else begin
            tgt_r    <= tgt_nxt;
            wait_r   <= wait_nxt;
            tgt_rd_r <= tgt_rd_nxt;
            cfg_r    <= cfg_nxt;
        end
    end

    // Acknowledge is driven only while the block is the target; it reads as an
    // input during mastered transfers.
    assign transfer_done_ack_oe_o = (tgt_r != lbm_pkg::LBM_T_IDLE);
    assign transfer_done_ack_n_o  = (tgt_r != lbm_pkg::LBM_T_ACK);

    // Byte bus: driven for mastered writes and for processor reads of the block.
    assign local_byte_bus_oe_o = ((mst_r == lbm_pkg::LBM_M_XFER) && cur_r.write) ||
                                 ((tgt_r != lbm_pkg::LBM_T_IDLE) && tgt_rd_r);
    assign local_byte_bus_o    = (mst_r == lbm_pkg::LBM_M_XFER) ? cur_r.wdata
                                                                : tgt_rdata_i;

    // Relinquish-and-retry: a new collision sets both flags and wins over any
    // release in the same cycle. Bus error drops once the strobe is high; halt
    // waits for the attention void cycle so the expansion bus rearbitrates.
    always_comb begin
        fault_nxt = fault_r;
        halt_nxt  = halt_r;
        if (fault_r && strobe_high) begin
            fault_nxt = 1'b0;
        end
        if (halt_r && attention_void_cycle_i) begin
            halt_nxt = 1'b0;
        end
        if (collision_i) begin
            fault_nxt = 1'b1;
            halt_nxt  = 1'b1;
        end
    end

    // Relinquish-and-retry registers.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_r <= 1'b0;
            halt_r  <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            halt_r  <= halt_nxt;
        end
    end

    assign fault_to_processor_n_o = ~fault_r;
    assign halt_n_o               = ~halt_r;

endmodule : lbm_bridge

// File: verif/lbm_bridge_properties.sv
`timescale 1ns/1ps
// Pin-level timing checks for the mastership, retry and acknowledge handshakes.
module lbm_bridge_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic exp_bus_req_i,
    input wire logic io_side_bus_req_i,
    input wire logic mastership_request_out_n_o,
    input wire logic grant_in_n_i,
    input wire logic mastership_taken_n_o,
    input wire logic xfer_done_o,
    input wire logic addr_valid_strobe_n_i,
    input wire logic transfer_done_ack_n_i,
    input wire logic transfer_done_ack_oe_o,
    input wire logic collision_i,
    input wire logic attention_void_cycle_i,
    input wire logic fault_to_processor_n_o,
    input wire logic halt_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Five free strobe cycles outlast the three synchroniser stages plus the accept edge.
    sequence strobe_quiet;
        (addr_valid_strobe_n_i && !collision_i)[*5];
    endsequence
    sequence strobe_free;
        addr_valid_strobe_n_i[*5];
    endsequence
    // A grant still seen low through the synchroniser holds a new request back.
    request_follows_a: assert property ((exp_bus_req_i || io_side_bus_req_i) &&
        mastership_request_out_n_o && $past(grant_in_n_i, 3) && $past(grant_in_n_i, 4)
        |=> !mastership_request_out_n_o) else $error("no request");
    grant_before_taken_a: assert property ($fell(mastership_taken_n_o) |->
        !$past(grant_in_n_i, 4)) else $error("taken without grant");
    release_together_a: assert property (mastership_request_out_n_o |->
        mastership_taken_n_o) else $error("taken outside request");
    retry_entry_a: assert property (collision_i |=>
        !fault_to_processor_n_o && !halt_n_o) else $error("retry not signalled");
    halt_hold_a: assert property (!halt_n_o && !attention_void_cycle_i |=>
        !halt_n_o) else $error("halt released early");
    halt_release_a: assert property (attention_void_cycle_i && !collision_i |=>
        halt_n_o) else $error("halt not released");
    fault_release_a: assert property (strobe_quiet |=>
        fault_to_processor_n_o) else $error("fault held after strobe");
    fault_strobe_a: assert property ($rose(fault_to_processor_n_o) |->
        $past(addr_valid_strobe_n_i, 4)) else $error("fault released with strobe low");
    ack_release_a: assert property (transfer_done_ack_oe_o ##0 strobe_free |=>
        !transfer_done_ack_oe_o) else $error("acknowledge drive kept");
    master_done_a: assert property ($rose(xfer_done_o) |->
        !$past(transfer_done_ack_n_i, 4)) else $error("done without acknowledge");
endmodule : lbm_bridge_properties

// File: verif/lbm_local_partner.sv
`timescale 1ns/1ps
// Local processor grant and local memory acknowledge, acting at falling edges.
module lbm_local_partner (
    input  wire logic       clk_i,
    input  wire logic       request_n_i,
    input  wire logic       taken_n_i,
    input  wire logic       ready_i,
    input  wire logic       done_i,
    input  wire logic       ack_oe_i,
    input  wire logic       ack_n_i,
    input  wire logic       bus_oe_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic [2:0] grant_dly_i,
    input  wire logic [2:0] ack_dly_i,
    output logic            grant_n_o,
    output logic            ack_pin_o,
    output logic [7:0]      bus_pin_o
);
    logic       busy;     // A mastered transfer waits for our acknowledge.
    logic       ack_drv;  // The local device pulls the acknowledge low.
    logic       rdy_q;    // Ready as seen at the previous falling edge.
    logic [2:0] gcnt;     // Cycles left before the grant.
    logic [2:0] acnt;     // Cycles left before the acknowledge.
    logic [7:0] idle_pat; // Changes every cycle so a stale byte never passes.
    initial begin
        grant_n_o = 1'b1;
        {busy, ack_drv, rdy_q, gcnt, acnt} = '0;
        idle_pat = 8'h5a;
    end
    // Grant comes after a chosen delay and is withdrawn as soon as the request goes.
    always @(negedge clk_i) begin
        idle_pat <= ~idle_pat;
        rdy_q <= ready_i;
        if (request_n_i) begin
            grant_n_o <= 1'b1;
            gcnt <= grant_dly_i;
        end else if (gcnt != 3'h0) gcnt <= gcnt - 3'h1;
        else grant_n_o <= 1'b0;
        // A falling ready marks a new transfer; done ends our part in it.
        if (done_i) begin
            busy <= 1'b0;
            ack_drv <= 1'b0;
        end else if (!taken_n_i && rdy_q && !ready_i) begin
            busy <= 1'b1;
            acnt <= ack_dly_i;
        end else if (busy && acnt != 3'h0) acnt <= acnt - 3'h1;
        else if (busy) ack_drv <= 1'b1;
    end
    // The acknowledge line has a pull-up, so it rests high when nobody pulls it.
    assign ack_pin_o = ack_oe_i ? ack_n_i : !ack_drv;
    assign bus_pin_o = bus_oe_i ? bus_i : (busy ? rdata_i : idle_pat);
endmodule : lbm_local_partner

// File: verif/lbm_bridge_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the local bus mastership bridge.
module lbm_bridge_tb;
    logic clk_i, sys_rst_i, phase_clock_early_i, phase_clock_late_i, internal_clk20_o;
    logic card_clock_out_o, exp_bus_req_i, io_side_bus_req_i, mastership_request_out_n_o;
    logic grant_in_n_i, mastership_taken_n_o, xfer_start_i, xfer_ready_o, xfer_done_o;
    logic addr_valid_strobe_n_i, transfer_done_ack_n_i, transfer_done_ack_n_o;
    logic transfer_done_ack_oe_o, local_byte_bus_oe_o, tgt_req_i, tgt_read_i, tgt_is_io_i;
    logic tgt_data_ready_i, cfg_load_i, collision_i, attention_void_cycle_i, halt_n_o;
    logic fault_to_processor_n_o;
    logic [7:0] xfer_rdata_o, local_byte_bus_i, local_byte_bus_o, tgt_rdata_i, pdata;
    logic [2:0] grant_dly, ack_dly;
    lbm_pkg::lbm_xfer_t    xfer_i;
    lbm_pkg::lbm_ack_cfg_t cfg_i;
    int miscompares, tests_run, lat0, lat, n;

    lbm_bridge u_lbm_bridge (.*);
    lbm_local_partner u_lbm_local_partner (.clk_i(clk_i),
        .request_n_i(mastership_request_out_n_o), .taken_n_i(mastership_taken_n_o),
        .ready_i(xfer_ready_o), .done_i(xfer_done_o), .ack_oe_i(transfer_done_ack_oe_o),
        .ack_n_i(transfer_done_ack_n_o), .bus_oe_i(local_byte_bus_oe_o),
        .bus_i(local_byte_bus_o), .rdata_i(pdata), .grant_dly_i(grant_dly),
        .ack_dly_i(ack_dly), .grant_n_o(grant_in_n_i), .ack_pin_o(transfer_done_ack_n_i),
        .bus_pin_o(local_byte_bus_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Early phase low in the first quarter, late phase low in the third.
    initial begin
        phase_clock_late_i = 1'b1;
        forever begin
            phase_clock_early_i = 1'b0;
            #25 phase_clock_early_i = 1'b1;
            #25 phase_clock_late_i = 1'b0;
            #25 phase_clock_late_i = 1'b1;
            #25;
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    function automatic logic cond(input int k);
        case (k)
            0: return mastership_taken_n_o === 1'b0;
            1: return xfer_ready_o === 1'b1;
            2: return xfer_done_o === 1'b1;
            3: return mastership_request_out_n_o === 1'b1;
            4: return transfer_done_ack_n_o === 1'b0 && transfer_done_ack_oe_o === 1'b1;
            5: return transfer_done_ack_oe_o === 1'b0;
            default: return fault_to_processor_n_o === 1'b1;
        endcase
    endfunction : cond
    // Waits at falling edges, with a bound, for condition k; rdy_at raises async ready.
    task automatic wait_for(input int k, input int rdy_at, output int c);
        c = 0;
        while (!cond(k) && c < 60) begin
            @(negedge clk_i);
            c++;
            if (c == rdy_at) tgt_data_ready_i = 1'b1;
        end
        check(8'(c < 60), 8'h01);
    endtask : wait_for
    // One processor access; c returns cycles until our acknowledge goes low.
    task automatic tgt_access(input logic io, input logic rd, input int rdy_at, output int c);
        tgt_data_ready_i = 1'b0;
        tgt_rdata_i = 8'($urandom);
        {tgt_is_io_i, tgt_read_i, tgt_req_i, addr_valid_strobe_n_i} = {io, rd, 2'b10};
        wait_for(4, rdy_at, c);
        if (rd) check(local_byte_bus_oe_o ? local_byte_bus_o : ~tgt_rdata_i, tgt_rdata_i);
        else check({7'h0, local_byte_bus_oe_o}, 8'h00);
        // The processor ends its cycle once it sees the acknowledge.
        {tgt_req_i, addr_valid_strobe_n_i} = 2'b01;
        wait_for(5, 0, n);
    endtask : tgt_access
    task automatic load_cfg(input logic am, input logic [3:0] w);
        cfg_i = '{async_mode: am, io_waits: w};
        cfg_load_i = 1'b1;
        @(negedge clk_i);
        cfg_load_i = 1'b0;
    endtask : load_cfg

    initial begin
        #(20000 * 100);
        miscompares++;
        wrap_up();
    end
    initial begin
        {exp_bus_req_i, io_side_bus_req_i, xfer_start_i, tgt_req_i, tgt_read_i} = '0;
        {tgt_is_io_i, tgt_data_ready_i, cfg_load_i, collision_i, attention_void_cycle_i} = '0;
        {xfer_i, cfg_i, pdata, grant_dly, ack_dly, tgt_rdata_i} = '0;
        {sys_rst_i, addr_valid_strobe_n_i} = 2'b11;
        void'($urandom(7));
        repeat (12) @(negedge clk_i);
        check({mastership_request_out_n_o, mastership_taken_n_o, fault_to_processor_n_o,
               halt_n_o, transfer_done_ack_oe_o, local_byte_bus_oe_o, xfer_done_o,
               transfer_done_ack_n_o}, 8'hf1);
        sys_rst_i = 1'b0;
        $display("Test reset done");
        // Sample the derived clocks at the middle of each quarter period.
        #(100 - $time % 100);
        for (int q = 0; q < 4; q++) begin
            #10 check({6'h0, internal_clk20_o, card_clock_out_o},
                      {6'h0, 8'hd9 >> (6 - 2 * q)} & 8'h03);
            #15;
        end
        @(negedge clk_i);
        $display("Test clocks done");
        for (int r = 0; r < 2; r++) begin
            grant_dly = 3'($urandom_range(7));
            {exp_bus_req_i, io_side_bus_req_i} = (r == 0) ? 2'b10 : 2'b01;
            wait_for(0, 0, n);
            check({7'h0, mastership_request_out_n_o}, 8'h00);
            for (int t = 0; t < 6; t++) begin
                wait_for(1, 0, n);
                xfer_i = '{write: 1'($urandom), wdata: 8'($urandom)};
                if (t == 0) xfer_i = '{write: 1'b1, wdata: 8'hff};
                pdata = (t == 1) ? 8'h00 : 8'($urandom);
                ack_dly = 3'($urandom_range(7));
                xfer_start_i = 1'b1;
                @(negedge clk_i);
                xfer_start_i = 1'b0;
                if (xfer_i.write) check(local_byte_bus_oe_o ? local_byte_bus_o
                                        : ~xfer_i.wdata, xfer_i.wdata);
                wait_for(2, 0, n);
                if (!xfer_i.write) check(xfer_rdata_o, pdata);
            end
            {exp_bus_req_i, io_side_bus_req_i} = 2'b00;
            wait_for(3, 0, n);
            check({7'h0, mastership_taken_n_o}, 8'h01);
        end
        $display("Test mastership done");
        tgt_access(1'b0, 1'b1, 99, lat0);
        for (int i = 0; i < 4; i++) begin
            load_cfg(1'b0, (i == 3) ? 4'hf : (i == 0) ? 4'h0 : 4'($urandom_range(14, 1)));
            tgt_access(1'b1, 1'(i % 2), 99, lat);
            check(8'(lat - lat0), {4'h0, cfg_i.io_waits});
        end
        load_cfg(1'b1, 4'h0);
        tgt_access(1'b0, 1'b1, 20, lat);
        check(8'(lat >= 20), 8'h01);
        $display("Test target done");
        // The strobe must be seen low through the synchroniser before the collision,
        // or the stale high level would drop the fault at once.
        addr_valid_strobe_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        collision_i = 1'b1;
        @(negedge clk_i);
        collision_i = 1'b0;
        check({6'h0, fault_to_processor_n_o, halt_n_o}, 8'h00);
        repeat (8) @(negedge clk_i);
        check({6'h0, fault_to_processor_n_o, halt_n_o}, 8'h00);
        addr_valid_strobe_n_i = 1'b1;
        wait_for(6, 0, n);
        check({7'h0, halt_n_o}, 8'h00);
        attention_void_cycle_i = 1'b1;
        @(negedge clk_i);
        attention_void_cycle_i = 1'b0;
        check({7'h0, halt_n_o}, 8'h01);
        $display("Test retry done");
        wrap_up();
    end
endmodule : lbm_bridge_tb

bind lbm_bridge lbm_bridge_properties u_lbm_bridge_properties (.*);
